// ### rtl/phy_link_map.svh
// Constants for the per-port link integrity and line coding block.
// Assumes a 100 MHz core clock and a plain strobe register port.
`ifndef PHY_LINK_MAP_SVH
`define PHY_LINK_MAP_SVH

// Clock rate
`define CLK_KHZ          100000
// Register indices
`define REG_STATUS       8'h01
`define REG_PORT_CTRL    8'h18
// Status fields
`define ST_LINK_PASS     2
`define ST_JABBER        1
`define ST_POL_INVERT    8
`define ST_POL_LOCKED    9
`define ST_PLL_LOCKED    10
`define ST_FEFI_ACTIVE   11
// Port control fields
`define CT_JABBER_OFF    12
`define CT_FEFI_FORCE    7
`define CT_FEFI_EN       6
`define CT_RESET         16'h0000
// Times in their own unit
`define JABBER_MS        50
`define UNJAB_MS         500
// Line coding counts
`define FEFI_ONES        16
`define FEFI_REPEATS     3
`define LOCK_TRANS       59
`define MAX_RUN          60
`define RX_DIV           5
`define RX_CLK_HIGH      2
`endif

// ### rtl/phy_link_pkg.sv
// Types for the per-port link integrity and line coding block.
// Constants live in phy_link_map.svh.
package phy_link_pkg;
  typedef struct packed {
    logic speed_100;
    logic fiber;
  } line_mode_s;

  typedef struct packed {
    logic [4:0] bits;
    logic       valid;
  } rx_word_s;

  typedef enum logic [1:0] {
    MLT_ZERO  = 2'b00,
    MLT_PLUS  = 2'b01,
    MLT_MINUS = 2'b11
  } mlt_level_e;

  typedef enum {LINK_FAIL, LINK_PASS} link_state_e;
  typedef enum {JAB_IDLE, JAB_TRIPPED, JAB_UNJAB} jab_state_e;
  typedef enum {POL_SEEK, POL_SET, POL_ONE, POL_LOCKED} pol_state_e;
endpackage

// ### rtl/phy_link_integrity.sv
// Per-port link integrity, jabber, polarity, far-end fault and line coding.
// Assumes all inputs synchronous to core_clk; line bits arrive as strobes.
//
// Contract
// - Start in link fail; pass only via negotiation.
// - Carrier sense follows qualified receive activity in pass.
// - 10M transmit too long disables transmit path.
// - Link test pulses continue while jabbered.
// - Jabber sets status bit in register 1.
// - Unjab interval after codec stream stops.
// - Carrier sense tracks receive pair during jabber.
// - Register 24 bit 12 disables jabber.
// - First link pulse sets receive polarity.
// - Polarity locks after two packets, while linked.
// - Polarity logic only in 10M twisted pair.
// - Fault pattern: ones then zero, three repeats.
// - Fault on no activity, PLL error, force bit.
// - Fault enable defaults by fiber mode, writable.
// - Three-level coder: one transitions, zero holds.
// - Copper line rate 125M, fundamental 31.25 MHz.
// - DC restoration bypassed in 10M twisted pair.
// - Recovered bit clock divided by five for receive.
// - Lock within 60 transitions; hold 60 bits.
// - Without valid data, receive clock uses transmit.
// - NRZI to NRZ, shifted into 5-bit words.
`timescale 1ns/1ns
`include "phy_link_map.svh"

module phy_link_integrity #(
  parameter int JABBER_CYCLES = `JABBER_MS * `CLK_KHZ,
  parameter int UNJAB_CYCLES  = `UNJAB_MS * `CLK_KHZ,
  parameter int FEFI_ONES     = `FEFI_ONES
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  // Register port
  input  wire logic [7:0]               reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [15:0]                   reg_rdata,
  // Port mode and negotiation
  input  wire phy_link_pkg::line_mode_s mode,
  input  wire logic                     an_link_ok,
  // Receive qualification and link pulses
  input  wire logic                     rx_activity,
  input  wire logic                     nlp_seen,
  input  wire logic                     nlp_inverted,
  input  wire logic                     rx_packet_end,
  // Transmit side from the codec
  input  wire logic                     codec_tx_active,
  input  wire logic                     tx_bit_en,
  input  wire logic                     tx_nrzi,
  // Recovered serial stream
  input  wire logic                     rec_bit_en,
  input  wire logic                     rec_bit,
  input  wire logic                     rec_signal_err,
  // Status toward the MAC
  output logic                          link_pass,
  output logic                          crs,
  output logic                          tx_path_en,
  output logic                          link_pulse_en,
  output logic                          polarity_invert,
  output logic                          dc_restore_en,
  // Line side
  output logic                          tx_line_bit,
  output phy_link_pkg::mlt_level_e      mlt_level,
  output logic                          fefi_active,
  // Receive toward the PCS
  output logic                          pll_locked,
  output logic                          rx_clk,
  output phy_link_pkg::rx_word_s        rx_word
);

  phy_link_pkg::link_state_e link_st;
  phy_link_pkg::jab_state_e  jab_st;
  phy_link_pkg::pol_state_e  pol_st;
  logic [15:0] port_ctrl;
  logic        jabber_flag;
  logic        fefi_en;
  logic        init_done;
  logic [31:0] jab_cnt;
  logic [1:0]  mlt_phase;
  logic [7:0]  fefi_cnt;
  logic [1:0]  fefi_rep;
  logic [6:0]  run_cnt;
  logic [6:0]  trans_cnt;
  logic        rec_prev;
  logic        nrzi_prev;
  logic [2:0]  div_cnt;
  logic [4:0]  shift;
  logic        is_10tp;
  logic        jab_on;
  logic        fefi_req;
  logic        bit_en;
  logic        status_rd;
  logic [15:0] status_word;

  // Mode decode and shared strobes
  assign is_10tp   = !mode.speed_100 && !mode.fiber;
  assign jab_on    = is_10tp && !port_ctrl[`CT_JABBER_OFF];
  assign bit_en    = pll_locked ? rec_bit_en : tx_bit_en;
  assign status_rd = reg_rd && reg_addr == `REG_STATUS;
  assign fefi_req  = fefi_en && (!rx_activity || rec_signal_err || !pll_locked || port_ctrl[`CT_FEFI_FORCE]);
  assign status_word = 16'(({15'h0, link_pass} << `ST_LINK_PASS) | ({15'h0, jabber_flag} << `ST_JABBER)
                     | ({15'h0, polarity_invert} << `ST_POL_INVERT)
                     | ({15'h0, pol_st == phy_link_pkg::POL_LOCKED} << `ST_POL_LOCKED)
                     | ({15'h0, pll_locked} << `ST_PLL_LOCKED) | ({15'h0, fefi_active} << `ST_FEFI_ACTIVE));

  // Register writes and read data one cycle later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_ctrl <= `CT_RESET;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `REG_PORT_CTRL) begin
        port_ctrl <= reg_wdata;
      end
      if (reg_rd && reg_addr == `REG_PORT_CTRL) begin
        reg_rdata <= port_ctrl;
      end else if (status_rd) begin
        reg_rdata <= status_word;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // Fault enable follows the mode at reset release, then software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      init_done <= 1'b0;
      fefi_en   <= 1'b0;
    end else begin
      init_done <= 1'b1;
      if (!init_done) begin
        fefi_en <= mode.fiber;
      end else if (reg_wr && reg_addr == `REG_PORT_CTRL) begin
        fefi_en <= reg_wdata[`CT_FEFI_EN];
      end
    end
  end

  // Link state and carrier sense
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_st   <= phy_link_pkg::LINK_FAIL;
      link_pass <= 1'b0;
      crs       <= 1'b0;
    end else begin
      unique case (link_st)
        phy_link_pkg::LINK_FAIL: if (an_link_ok) link_st <= phy_link_pkg::LINK_PASS;
        phy_link_pkg::LINK_PASS: if (!an_link_ok) link_st <= phy_link_pkg::LINK_FAIL;
      endcase
      link_pass <= link_st == phy_link_pkg::LINK_PASS;
      crs       <= link_st == phy_link_pkg::LINK_PASS && rx_activity;
    end
  end

  // Jabber timer and unjab recovery
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      jab_st  <= phy_link_pkg::JAB_IDLE;
      jab_cnt <= 32'h0;
    end else if (!jab_on) begin
      jab_st  <= phy_link_pkg::JAB_IDLE;
      jab_cnt <= 32'h0;
    end else begin
      unique case (jab_st)
        phy_link_pkg::JAB_IDLE: begin
          if (!codec_tx_active) begin
            jab_cnt <= 32'h0;
          end else if (jab_cnt == 32'(JABBER_CYCLES - 1)) begin
            jab_st  <= phy_link_pkg::JAB_TRIPPED;
            jab_cnt <= 32'h0;
          end else begin
            jab_cnt <= jab_cnt + 32'h1;
          end
        end
        phy_link_pkg::JAB_TRIPPED: begin
          if (!codec_tx_active) jab_st <= phy_link_pkg::JAB_UNJAB;
        end
        phy_link_pkg::JAB_UNJAB: begin
          if (codec_tx_active) begin
            jab_st  <= phy_link_pkg::JAB_TRIPPED;
            jab_cnt <= 32'h0;
          end else if (jab_cnt == 32'(UNJAB_CYCLES - 1)) begin
            jab_st  <= phy_link_pkg::JAB_IDLE;
            jab_cnt <= 32'h0;
          end else begin
            jab_cnt <= jab_cnt + 32'h1;
          end
        end
      endcase
    end
  end

  // Path enable, link pulses, sticky jabber flag cleared by status read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_path_en    <= 1'b0;
      link_pulse_en <= 1'b0;
      dc_restore_en <= 1'b0;
      jabber_flag   <= 1'b0;
    end else begin
      tx_path_en    <= jab_st == phy_link_pkg::JAB_IDLE;
      link_pulse_en <= !mode.speed_100;
      dc_restore_en <= !is_10tp;
      if (jab_st == phy_link_pkg::JAB_TRIPPED) begin
        jabber_flag <= 1'b1;
      end else if (status_rd) begin
        jabber_flag <= 1'b0;
      end
    end
  end

  // Polarity detect on first link pulse, lock after two packets
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pol_st          <= phy_link_pkg::POL_SEEK;
      polarity_invert <= 1'b0;
    end else if (!is_10tp) begin
      pol_st          <= phy_link_pkg::POL_SEEK;
      polarity_invert <= 1'b0;
    end else begin
      unique case (pol_st)
        phy_link_pkg::POL_SEEK: if (nlp_seen) begin
          polarity_invert <= nlp_inverted;
          pol_st          <= phy_link_pkg::POL_SET;
        end
        phy_link_pkg::POL_SET:  if (rx_packet_end) pol_st <= phy_link_pkg::POL_ONE;
        phy_link_pkg::POL_ONE:  if (rx_packet_end) pol_st <= phy_link_pkg::POL_LOCKED;
        phy_link_pkg::POL_LOCKED: if (!link_pass) pol_st <= phy_link_pkg::POL_SEEK;
      endcase
    end
  end

  // Far-end fault pattern runs at least three full repeats
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fefi_active <= 1'b0;
      fefi_cnt    <= 8'h0;
      fefi_rep    <= 2'h0;
    end else if (!fefi_active) begin
      fefi_active <= fefi_req;
      fefi_cnt    <= 8'h0;
      fefi_rep    <= 2'h0;
    end else if (bit_en) begin
      if (fefi_cnt == 8'(FEFI_ONES)) begin
        fefi_cnt <= 8'h0;
        if (fefi_rep != 2'(`FEFI_REPEATS - 1)) begin
          fefi_rep <= fefi_rep + 2'h1;
        end else if (!fefi_req) begin
          fefi_active <= 1'b0;
        end
      end else begin
        fefi_cnt <= fefi_cnt + 8'h1;
      end
    end
  end

  // Line bit and three-level coder, one step per bit strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_line_bit <= 1'b0;
      mlt_phase   <= 2'h0;
      mlt_level   <= phy_link_pkg::MLT_ZERO;
    end else if (tx_bit_en) begin
      tx_line_bit <= fefi_active ? (fefi_cnt != 8'(FEFI_ONES)) : tx_nrzi;
      if (fefi_active ? (fefi_cnt != 8'(FEFI_ONES)) : tx_nrzi) begin
        mlt_phase <= mlt_phase + 2'h1;
        unique case (mlt_phase + 2'h1)
          2'h1:    mlt_level <= phy_link_pkg::MLT_PLUS;
          2'h3:    mlt_level <= phy_link_pkg::MLT_MINUS;
          default: mlt_level <= phy_link_pkg::MLT_ZERO;
        endcase
      end
    end
  end

  // Recovery lock: transitions to acquire, run length to drop
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pll_locked <= 1'b0;
      run_cnt    <= 7'h0;
      trans_cnt  <= 7'h0;
      rec_prev   <= 1'b0;
    end else if (rec_bit_en) begin
      rec_prev <= rec_bit;
      if (rec_bit != rec_prev) begin
        run_cnt <= 7'h0;
        if (!pll_locked) begin
          if (trans_cnt == 7'(`LOCK_TRANS - 1)) begin
            pll_locked <= 1'b1;
          end
          trans_cnt <= trans_cnt + 7'h1;
        end
      end else if (run_cnt == 7'(`MAX_RUN)) begin
        pll_locked <= 1'b0;
        trans_cnt  <= 7'h0;
      end else begin
        run_cnt <= run_cnt + 7'h1;
      end
    end
  end

  // Divide-by-five receive clock and NRZI to NRZ word shifter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt   <= 3'h0;
      rx_clk    <= 1'b0;
      nrzi_prev <= 1'b0;
      shift     <= 5'h0;
      rx_word   <= '0;
    end else begin
      rx_word.valid <= 1'b0;
      // Previous line bit follows every strobe, so the first bit after lock decodes right
      if (rec_bit_en) begin
        nrzi_prev <= rec_bit;
      end
      if (bit_en) begin
        div_cnt <= (div_cnt == 3'(`RX_DIV - 1)) ? 3'h0 : div_cnt + 3'h1;
        rx_clk  <= div_cnt < 3'(`RX_CLK_HIGH);
        if (pll_locked) begin
          shift     <= {shift[3:0], rec_bit ^ nrzi_prev};
          if (div_cnt == 3'(`RX_DIV - 1)) begin
            rx_word.bits  <= {shift[3:0], rec_bit ^ nrzi_prev};
            rx_word.valid <= 1'b1;
          end
        end
      end
    end
  end

  // Checks
  sequence s_jab_run;
    jab_st == phy_link_pkg::JAB_TRIPPED;
  endsequence
  sequence s_path_off;
    !tx_path_en;
  endsequence
  property p_link_needs_an;
    @(posedge core_clk) disable iff (rst) $rose(link_pass) |-> $past(an_link_ok, 2);
  endproperty
  a_link_needs_an: assert property (p_link_needs_an) else $error("link pass without negotiation");
  property p_crs_track;
    @(posedge core_clk) disable iff (rst) (link_st == phy_link_pkg::LINK_PASS && rx_activity) |=> crs;
  endproperty
  a_crs_track: assert property (p_crs_track) else $error("carrier sense missed activity");
  property p_crs_idle;
    @(posedge core_clk) disable iff (rst) !rx_activity |=> !crs;
  endproperty
  a_crs_idle: assert property (p_crs_idle) else $error("carrier sense without activity");
  property p_jab_cuts;
    @(posedge core_clk) disable iff (rst) s_jab_run |=> s_path_off;
  endproperty
  a_jab_cuts: assert property (p_jab_cuts) else $error("path still on after jabber");
  property p_jab_flag;
    @(posedge core_clk) disable iff (rst) s_jab_run |=> jabber_flag;
  endproperty
  a_jab_flag: assert property (p_jab_flag) else $error("jabber flag not set");
  property p_jab_off;
    @(posedge core_clk) disable iff (rst) (!jab_on ##1 !jab_on) |=> tx_path_en;
  endproperty
  a_jab_off: assert property (p_jab_off) else $error("path off with jabber disabled");
  property p_pol_hold;
    @(posedge core_clk) disable iff (rst)
      (pol_st == phy_link_pkg::POL_LOCKED && is_10tp && link_pass) |=> $stable(polarity_invert);
  endproperty
  a_pol_hold: assert property (p_pol_hold) else $error("locked polarity changed");
  property p_mlt_zero;
    @(posedge core_clk) disable iff (rst) (tx_bit_en && !fefi_active && !tx_nrzi) |=> $stable(mlt_level);
  endproperty
  a_mlt_zero: assert property (p_mlt_zero) else $error("coder moved on a zero");
  property p_mlt_step;
    @(posedge core_clk) disable iff (rst) $changed(mlt_level) |-> (mlt_level == phy_link_pkg::MLT_ZERO
      || $past(mlt_level) == phy_link_pkg::MLT_ZERO);
  endproperty
  a_mlt_step: assert property (p_mlt_step) else $error("coder jumped between extremes");
  property p_dc_bypass;
    @(posedge core_clk) disable iff (rst) is_10tp |=> !dc_restore_en;
  endproperty
  a_dc_bypass: assert property (p_dc_bypass) else $error("DC restore on in 10M");

endmodule

// ### tb/phy_link_partner.sv
// Remote partner model: sends an NRZI bit stream, one strobe per bit.
// Assumes the bench sets the NRZ value and the pace; all on core_clk.
`timescale 1ns/1ns

module phy_link_partner (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Control from the bench
  input  wire logic run,
  input  wire logic slow,
  input  wire logic nrz,
  // Recovered stream toward the block
  output logic      rec_bit_en,
  output logic      rec_bit
);
  logic [1:0] pace;
  logic       level;
  logic       fire;

  assign fire = run && (pace == 2'h0);

  // Bit pace: every cycle, or every third cycle when slow
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pace <= 2'h0;
    end else begin
      pace <= (pace == 2'h2 || !slow) ? 2'h0 : pace + 2'h1;
    end
  end

  // Line level: a one flips it, a zero holds it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
    end else if (fire) begin
      level <= level ^ nrz;
    end
  end

  // Between bits the line flips, so stale data is never mistaken for a bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rec_bit_en <= 1'b0;
      rec_bit    <= 1'b0;
    end else begin
      rec_bit_en <= fire;
      rec_bit    <= fire ? (level ^ nrz) : ~rec_bit;
    end
  end
endmodule

// ### tb/phy_link_integrity_tb_top.sv
// Directed bench for the link integrity block: register tasks and checks.
// Assumes the partner model drives the recovered stream; short jabber counts.
`timescale 1ns/1ns
`include "phy_link_map.svh"

module phy_link_integrity_tb_top;
  localparam int FONES = 4;
  logic                     core_clk, rst, reg_wr, reg_rd;
  logic [7:0]               reg_addr;
  logic [15:0]              reg_wdata, reg_rdata, v;
  phy_link_pkg::line_mode_s mode;
  logic                     an_link_ok, rx_activity, nlp_seen, nlp_inverted, rx_packet_end;
  logic                     codec_tx_active, tx_bit_en, tx_nrzi, rec_bit_en, rec_bit, rec_signal_err;
  logic                     link_pass, crs, tx_path_en, link_pulse_en, polarity_invert, dc_restore_en;
  logic                     tx_line_bit, fefi_active, pll_locked, rx_clk, p_run, p_nrz;
  phy_link_pkg::mlt_level_e mlt_level;
  phy_link_pkg::rx_word_s   rx_word;
  logic [4:0]               last_word;
  int                       miscompares, comparisons, n;

  phy_link_integrity #(.JABBER_CYCLES(20), .UNJAB_CYCLES(40), .FEFI_ONES(FONES)) phy_link_integrity_inst (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode(mode), .an_link_ok(an_link_ok),
    .rx_activity(rx_activity), .nlp_seen(nlp_seen), .nlp_inverted(nlp_inverted),
    .rx_packet_end(rx_packet_end), .codec_tx_active(codec_tx_active), .tx_bit_en(tx_bit_en),
    .tx_nrzi(tx_nrzi), .rec_bit_en(rec_bit_en), .rec_bit(rec_bit), .rec_signal_err(rec_signal_err),
    .link_pass(link_pass), .crs(crs), .tx_path_en(tx_path_en), .link_pulse_en(link_pulse_en),
    .polarity_invert(polarity_invert), .dc_restore_en(dc_restore_en), .tx_line_bit(tx_line_bit),
    .mlt_level(mlt_level), .fefi_active(fefi_active), .pll_locked(pll_locked), .rx_clk(rx_clk),
    .rx_word(rx_word));

  phy_link_partner phy_link_partner_inst (.core_clk(core_clk), .rst(rst), .run(p_run), .slow(1'b0),
    .nrz(p_nrz), .rec_bit_en(rec_bit_en), .rec_bit(rec_bit));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Keep the newest receive word
  always @(posedge core_clk) if (rx_word.valid === 1'b1) last_word <= rx_word.bits;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic nlp(input logic inv);
    @(posedge core_clk);
    nlp_seen     <= 1'b1;
    nlp_inverted <= inv;
    @(posedge core_clk);
    nlp_seen <= 1'b0;
    cyc(2);
  endtask
  task automatic pkt();
    @(posedge core_clk);
    rx_packet_end <= 1'b1;
    @(posedge core_clk);
    rx_packet_end <= 1'b0;
  endtask
  task automatic drive(input int sel, input logic val);
    @(posedge core_clk);
    case (sel)
      0: rx_activity <= val;
      1: an_link_ok <= val;
      2: codec_tx_active <= val;
      3: tx_bit_en <= val;
      4: p_run <= val;
      5: p_nrz <= val;
      default: rec_signal_err <= val;
    endcase
  endtask
  task automatic do_reset(input logic spd, input logic fib);
    @(posedge core_clk);
    rst  <= 1'b1;
    mode <= '{speed_100: spd, fiber: fib};
    cyc(10);
    chk(16'({link_pass, crs, fefi_active, pll_locked, mlt_level}), 16'h0);
    @(posedge core_clk);
    rst <= 1'b0;
    cyc(2);
  endtask
  // Count rising edges of the receive clock over 50 cycles
  task automatic rx_edges();
    logic prev;
    n    = 0;
    prev = rx_clk;
    repeat (50) begin
      cyc(1);
      if (rx_clk === 1'b1 && prev === 1'b0) n++;
      prev = rx_clk;
    end
  endtask
  // Every zero after the first must follow exactly FONES ones
  task automatic fault_run();
    int run   = 0;
    int zeros = 0;
    repeat (5 * (FONES + 1)) begin
      cyc(1);
      if (tx_line_bit === 1'b1) begin
        run++;
      end else begin
        if (zeros > 0) chk(16'(run), 16'(FONES));
        zeros++;
        run = 0;
      end
    end
    chk(16'(zeros >= 3), 16'h1);
  endtask
  task automatic summarize();
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    #100000;
    miscompares++;
    summarize();
  end

  // Main sequence
  initial begin : main
    phy_link_pkg::mlt_level_e lv [6];
    logic [5:0] bits;
    lv   = '{phy_link_pkg::MLT_PLUS, phy_link_pkg::MLT_ZERO, phy_link_pkg::MLT_MINUS,
             phy_link_pkg::MLT_ZERO, phy_link_pkg::MLT_ZERO, phy_link_pkg::MLT_PLUS};
    bits = 6'b101111;
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, mode, an_link_ok, rx_activity} = '0;
    {nlp_seen, nlp_inverted, rx_packet_end, codec_tx_active, tx_bit_en, tx_nrzi} = '0;
    {rec_signal_err, p_run, p_nrz, miscompares, comparisons} = '0;
    rst = 1'b1;
    // Ten megabit twisted pair
    do_reset(1'b0, 1'b0);
    chk(16'({link_pass, link_pulse_en, dc_restore_en, tx_path_en}), 16'h5);
    rd(8'h05);
    chk(v, 16'h0);
    wr(`REG_STATUS, 16'hffff);
    rd(`REG_STATUS);
    chk(v, 16'h0);
    drive(0, 1'b1);
    cyc(3);
    chk(16'(crs), 16'h0);
    drive(1, 1'b1);
    cyc(1);
    chk(16'(link_pass), 16'h0);
    cyc(3);
    chk(16'({link_pass, crs}), 16'h3);
    // Jabber trip, carrier tracking, unjab
    drive(2, 1'b1);
    cyc(10);
    chk(16'(tx_path_en), 16'h1);
    cyc(20);
    chk(16'({tx_path_en, link_pulse_en}), 16'h1);
    drive(0, 1'b0);
    cyc(2);
    chk(16'(crs), 16'h0);
    drive(0, 1'b1);
    cyc(2);
    chk(16'(crs), 16'h1);
    rd(`REG_STATUS);
    chk(16'(v[`ST_JABBER]), 16'h1);
    drive(2, 1'b0);
    cyc(20);
    chk(16'(tx_path_en), 16'h0);
    cyc(40);
    chk(16'(tx_path_en), 16'h1);
    rd(`REG_STATUS);
    chk(16'(v[`ST_JABBER]), 16'h1);
    rd(`REG_STATUS);
    chk(16'(v[`ST_JABBER]), 16'h0);
    wr(`REG_PORT_CTRL, 16'h1 << `CT_JABBER_OFF);
    rd(`REG_PORT_CTRL);
    chk(v & 16'h10c0, 16'h1000);
    drive(2, 1'b1);
    cyc(40);
    chk(16'(tx_path_en), 16'h1);
    drive(2, 1'b0);
    // Polarity
    nlp(1'b1);
    chk(16'(polarity_invert), 16'h1);
    nlp(1'b0);
    chk(16'(polarity_invert), 16'h1);
    pkt();
    pkt();
    rd(`REG_STATUS);
    chk(16'({v[`ST_POL_LOCKED], v[`ST_POL_INVERT]}), 16'h3);
    drive(1, 1'b0);
    cyc(5);
    rd(`REG_STATUS);
    chk(16'(v[`ST_POL_LOCKED]), 16'h0);
    drive(0, 1'b0);
    // Hundred megabit copper: line coder, clocks, recovery
    do_reset(1'b1, 1'b0);
    chk(16'({dc_restore_en, fefi_active}), 16'h2);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      tx_bit_en <= 1'b1;
      tx_nrzi   <= bits[i];
      @(posedge core_clk);
      tx_bit_en <= 1'b0;
      #1;
      chk(16'(mlt_level), 16'(lv[i]));
    end
    drive(3, 1'b1);
    rx_edges();
    chk(16'(n), 16'd10);
    drive(3, 1'b0);
    drive(5, 1'b1);
    drive(4, 1'b1);
    cyc(30);
    chk(16'(pll_locked), 16'h0);
    cyc(35);
    chk(16'(pll_locked), 16'h1);
    cyc(12);
    chk(16'(last_word), 16'h1f);
    rx_edges();
    chk(16'(n), 16'd10);
    drive(5, 1'b0);
    cyc(12);
    chk(16'(last_word), 16'h0);
    cyc(38);
    chk(16'(pll_locked), 16'h1);
    cyc(25);
    chk(16'(pll_locked), 16'h0);
    drive(4, 1'b0);
    wr(`REG_PORT_CTRL, 16'h1 << `CT_FEFI_EN);
    cyc(2);
    chk(16'(fefi_active), 16'h1);
    // Fiber: fault defaults on, pattern, causes
    do_reset(1'b1, 1'b1);
    chk(16'(fefi_active), 16'h1);
    nlp(1'b1);
    chk(16'(polarity_invert), 16'h0);
    drive(3, 1'b1);
    fault_run();
    drive(3, 1'b0);
    drive(5, 1'b1);
    drive(4, 1'b1);
    drive(0, 1'b1);
    cyc(70);
    chk(16'(fefi_active), 16'h0);
    wr(`REG_PORT_CTRL, (16'h1 << `CT_FEFI_EN) | (16'h1 << `CT_FEFI_FORCE));
    cyc(3);
    chk(16'(fefi_active), 16'h1);
    wr(`REG_PORT_CTRL, 16'h1 << `CT_FEFI_EN);
    cyc(3);
    chk(16'(fefi_active), 16'h1);
    cyc(9);
    chk(16'(fefi_active), 16'h0);
    drive(6, 1'b1);
    cyc(3);
    chk(16'(fefi_active), 16'h1);
    drive(6, 1'b0);
    cyc(20);
    chk(16'(fefi_active), 16'h0);
    drive(0, 1'b0);
    cyc(3);
    chk(16'(fefi_active), 16'h1);
    summarize();
  end
endmodule
